// ===== rtl/mer_host.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module mer_host (
    // register link
    mer_link_if.host link,
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    output logic irq
);

    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} mer_hstate_e;

    mer_hstate_e state;
    logic [1:0] op;
    logic [1:0] step;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_do;
    logic start;
    logic done;
    logic [7:0] last_rdata;
    logic [7:0] last_event;
    logic [15:0] sum_x;
    logic [15:0] sum_y;
    logic [15:0] expo;
    logic [mer_pkg::IRQ_W-1:0] irq_status;
    logic [mer_pkg::IRQ_W-1:0] irq_mask;
    logic [mer_pkg::IRQ_W-1:0] irq_set;
    logic [31:0] next_rdata;
    logic rd_hit;
    logic got;

    ////////////////////////////////////////////////////////////////////////////
    // address and data held until both are in, then one write
    assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign start = wr_do && (aw_addr == mer_pkg::CSR_CTRL) && (w_strb == mer_pkg::STRB_ALL)
        && (state == H_IDLE);
    assign got = (state == H_WAIT) && link.ack;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mer_pkg::RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bresp <= (aw_addr > mer_pkg::CSR_IRQ_MASK || aw_addr[1:0] != 2'h0)
                    ? mer_pkg::RESP_SLVERR : mer_pkg::RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= H_IDLE;
            op <= mer_pkg::OP_READ;
            step <= '0;
            link.req <= 1'b0;
            link.we <= 1'b0;
            link.addr <= '0;
            link.wdata <= '0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (start) begin
                        op <= w_data[mer_pkg::CTRL_OP_LSB +: 2];
                        step <= '0;
                        link.we <= w_data[mer_pkg::CTRL_OP_LSB +: 2] == mer_pkg::OP_WRITE;
                        link.wdata <= w_data[mer_pkg::CTRL_DATA_LSB +: 8];
                        unique case (w_data[mer_pkg::CTRL_OP_LSB +: 2])
                            mer_pkg::OP_POLL: link.addr <= mer_pkg::ADDR_EVENT;
                            mer_pkg::OP_EXPO: link.addr <= mer_pkg::ADDR_EXP_HI;
                            default: link.addr <= w_data[mer_pkg::CTRL_ADDR_LSB +: 8];
                        endcase
                        state <= H_ISSUE;
                    end
                end
                H_ISSUE: begin
                    link.req <= 1'b1;
                    state <= H_WAIT;
                end
                H_WAIT: begin
                    if (link.ack) begin
                        link.req <= 1'b0;
                        state <= H_ISSUE;
                        step <= step + 2'h1;
                        if (done) begin
                            state <= H_IDLE;
                        end else if (op == mer_pkg::OP_EXPO) begin
                            link.addr <= mer_pkg::ADDR_EXP_LO;
                        end else if (step == 2'h0) begin
                            // X then Y back to back
                            link.addr <= mer_pkg::ADDR_DX;
                        end else if (step == 2'h1) begin
                            link.addr <= mer_pkg::ADDR_DY;
                        end else begin
                            link.addr <= mer_pkg::ADDR_EVENT;
                            step <= '0;
                        end
                    end
                end
            endcase
        end
    end

    always_comb begin
        done = 1'b1;
        if (op == mer_pkg::OP_POLL) begin
            done = (step == 2'h0) && !link.rdata[mer_pkg::EV_MOTION];
        end else if (op == mer_pkg::OP_EXPO) begin
            done = step == 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // results
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_rdata <= '0;
            last_event <= '0;
            sum_x <= '0;
            sum_y <= '0;
            expo <= '0;
        end else if (start && w_data[mer_pkg::CTRL_OP_LSB +: 2] == mer_pkg::OP_POLL) begin
            sum_x <= '0;
            sum_y <= '0;
        end else if (got) begin
            last_rdata <= link.rdata;
            if (op == mer_pkg::OP_EXPO) begin
                if (step == 2'h0) begin
                    expo[15:8] <= link.rdata;
                end else begin
                    expo[7:0] <= link.rdata;
                end
            end else if (op == mer_pkg::OP_POLL) begin
                if (step == 2'h0) begin
                    last_event <= link.rdata;
                end else if (step == 2'h1) begin
                    sum_x <= sum_x + {{8{link.rdata[7]}}, link.rdata};
                end else begin
                    sum_y <= sum_y + {{8{link.rdata[7]}}, link.rdata};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: set wins over write-one-to-clear
    always_comb begin
        irq_set = '0;
        irq_set[mer_pkg::IRQ_DONE] = got && done;
        irq_set[mer_pkg::IRQ_MOTION] = got && (op == mer_pkg::OP_POLL) && (step == 2'h0)
            && link.rdata[mer_pkg::EV_MOTION];
        irq_set[mer_pkg::IRQ_OVF] = got && (op == mer_pkg::OP_POLL) && (step == 2'h0)
            && link.rdata[mer_pkg::EV_OVF];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_do && w_strb[0] && aw_addr == mer_pkg::CSR_IRQ_STATUS) begin
                irq_status <= (irq_status & ~w_data[mer_pkg::IRQ_W-1:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
            if (wr_do && w_strb[0] && aw_addr == mer_pkg::CSR_IRQ_MASK) begin
                irq_mask <= w_data[mer_pkg::IRQ_W-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel: answer one cycle after the address is taken
    always_comb begin
        next_rdata = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            mer_pkg::CSR_CTRL: next_rdata = '0;
            mer_pkg::CSR_STATUS: next_rdata = {8'h00, last_event, last_rdata, 7'h00, state != H_IDLE};
            mer_pkg::CSR_MOTION: next_rdata = {sum_y, sum_x};
            mer_pkg::CSR_EXPOSURE: next_rdata = {16'h0000, expo};
            mer_pkg::CSR_IRQ_STATUS: next_rdata[mer_pkg::IRQ_W-1:0] = irq_status;
            mer_pkg::CSR_IRQ_MASK: next_rdata[mer_pkg::IRQ_W-1:0] = irq_mask;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= mer_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_hit ? mer_pkg::RESP_OKAY : mer_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ===== rtl/mer_pkg.sv
package mer_pkg;
    // sensor register map
    localparam logic [7:0] ADDR_EVENT = 8'h02;
    localparam logic [7:0] ADDR_DX = 8'h03;
    localparam logic [7:0] ADDR_DY = 8'h04;
    localparam logic [7:0] ADDR_SURFACE_QUALITY = 8'h05;
    localparam logic [7:0] ADDR_EXP_HI = 8'h06;
    localparam logic [7:0] ADDR_EXP_LO = 8'h07;
    localparam logic [7:0] ADDR_PIXEL = 8'h0B;
    localparam logic [7:0] ADDR_BUTTON = 8'h12;
    localparam logic [7:0] ADDR_FINGER = 8'h7A;
    localparam logic [7:0] ADDR_TAP = 8'h7F;
    // event flag bit positions
    localparam int EV_MOTION = 7;
    localparam int EV_PIX_RDY = 6;
    localparam int EV_PIX_FIRST = 5;
    localparam int EV_OVF = 4;
    localparam int EV_RESET = 3;
    localparam int EV_BUTTON = 2;
    localparam int EV_TAP = 1;
    localparam int EV_FINGER = 0;
    // motion accumulation
    localparam int ACC_W = 12;
    localparam logic signed [ACC_W-1:0] ACC_MAX = 12'sh7FF;
    localparam logic signed [ACC_W-1:0] ACC_MIN = 12'sh800;
    localparam logic signed [ACC_W-1:0] REP_MAX = 12'sh07F;
    localparam logic signed [ACC_W-1:0] REP_MIN = 12'shF80;
    localparam logic [7:0] SURFACE_QUALITY_MAX = 8'hA7;
    // controller registers, byte addresses
    localparam logic [7:0] CSR_CTRL = 8'h00;
    localparam logic [7:0] CSR_STATUS = 8'h04;
    localparam logic [7:0] CSR_MOTION = 8'h08;
    localparam logic [7:0] CSR_EXPOSURE = 8'h0C;
    localparam logic [7:0] CSR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] CSR_IRQ_MASK = 8'h14;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_ADDR_LSB = 8;
    localparam int CTRL_DATA_LSB = 16;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_POLL = 2'h2;
    localparam logic [1:0] OP_EXPO = 2'h3;
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_MOTION = 1;
    localparam int IRQ_OVF = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] STRB_ALL = 4'hF;
endpackage

// ===== rtl/mer_link_if.sv
`timescale 1ns/1ps
interface mer_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    modport device (input req, we, addr, wdata, output ack, rdata);
    modport host (output req, we, addr, wdata, input ack, rdata);
endinterface

// ===== rtl/mer_device.sv
// Contract
// - eight event flags, motion down to finger
// - event write clears motion, overflow, counts
// - host reads flags before motion counts
// - wide accumulators, overflow sets overflow flag
// - overflow clears after read, not full
// - host repeats reads until motion clear
// - pixel ready flag before pixel read
// - pixel first on port write or wrap
// - reset sets flag, event write clears
// - button click flag, cleared by read
// - tap click flag, cleared by read
// - finger toggle flag, cleared by read
// - motion flag follows pending motion data
// - X count saturating, read takes reported part out
// - Y count saturating, read takes reported part out
// - host reads X then Y together
// - surface quality upper bits, max 167
// - exposure sixteen bits, high then low
`timescale 1ns/1ps
module mer_device (
    // register link
    mer_link_if.device link,
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sensor core
    input wire logic soft_reset,
    input wire logic motion_valid,
    input wire logic signed [7:0] motion_dx,
    input wire logic signed [7:0] motion_dy,
    input wire logic [8:0] feature_count,
    input wire logic [15:0] exposure,
    // detectors
    input wire logic button_click,
    input wire logic tap_click,
    input wire logic finger_present,
    input wire logic [7:0] button_state,
    input wire logic [7:0] tap_state,
    // pixel readout
    input wire logic pixel_valid,
    input wire logic [7:0] pixel_byte,
    input wire logic pixel_wrap,
    output logic pixel_restart,
    output logic pixel_advance
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic t, input logic [7:0] a, input logic [7:0] r);
        return t && (a == r);
    endfunction

    function automatic logic [7:0] sat8(input logic signed [mer_pkg::ACC_W-1:0] v);
        if (v > mer_pkg::REP_MAX) begin
            return mer_pkg::REP_MAX[7:0];
        end
        if (v < mer_pkg::REP_MIN) begin
            return mer_pkg::REP_MIN[7:0];
        end
        return v[7:0];
    endfunction

    logic take;
    logic rd;
    logic wr;
    logic wr_event;
    logic rd_pixel;
    logic [1:0] rd_axis;
    logic [1:0] sat_axis;
    logic [1:0] full_axis;
    logic signed [mer_pkg::ACC_W-1:0] acc [2];
    logic signed [7:0] delta [2];
    logic [7:0] rep [2];
    logic motion_flag;
    logic overflow_flag;
    logic reset_seen_flag;
    logic finger_prev;
    logic [4:0] sticky;
    logic [4:0] sticky_set;
    logic [4:0] sticky_clr;
    logic [7:0] exp_low_hold;
    logic [7:0] surface_quality;
    logic [7:0] event_byte;
    logic [7:0] next_rdata;

    // a request is taken once; the ack cycle masks the still-high req
    assign take = link.req && !link.ack;
    assign rd = take && !link.we;
    assign wr = take && link.we;
    assign wr_event = hit(wr, link.addr, mer_pkg::ADDR_EVENT);
    assign rd_pixel = hit(rd, link.addr, mer_pkg::ADDR_PIXEL);
    assign rd_axis[0] = hit(rd, link.addr, mer_pkg::ADDR_DX);
    assign rd_axis[1] = hit(rd, link.addr, mer_pkg::ADDR_DY);
    assign delta[0] = motion_dx;
    assign delta[1] = motion_dy;

    ////////////////////////////////////////////////////////////////////////////
    // motion accumulators, one per axis
    for (genvar g = 0; g < 2; g++) begin : g_axis
        logic signed [mer_pkg::ACC_W:0] base;
        logic signed [mer_pkg::ACC_W:0] sum;

        assign rep[g] = sat8(acc[g]);

        always_comb begin
            base = {acc[g][mer_pkg::ACC_W-1], acc[g]};
            // read takes the reported part out
            if (rd_axis[g]) begin
                base = base - {{(mer_pkg::ACC_W-7){rep[g][7]}}, rep[g]};
            end
            if (wr_event) begin
                base = '0;
            end
            // new motion still lands in a clearing cycle
            if (motion_valid) begin
                sum = base + {{(mer_pkg::ACC_W-7){delta[g][7]}}, delta[g]};
            end else begin
                sum = base;
            end
        end

        // overflow detect on the wide buffer
        assign sat_axis[g] = (sum > $signed({mer_pkg::ACC_MAX[mer_pkg::ACC_W-1], mer_pkg::ACC_MAX}))
            || (sum < $signed({mer_pkg::ACC_MIN[mer_pkg::ACC_W-1], mer_pkg::ACC_MIN}));
        assign full_axis[g] = sat_axis[g] || (sum[mer_pkg::ACC_W-1:0] == mer_pkg::ACC_MAX)
            || (sum[mer_pkg::ACC_W-1:0] == mer_pkg::ACC_MIN);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                acc[g] <= '0;
            end else if (sat_axis[g]) begin
                acc[g] <= sum[mer_pkg::ACC_W] ? mer_pkg::ACC_MIN : mer_pkg::ACC_MAX;
            end else begin
                acc[g] <= sum[mer_pkg::ACC_W-1:0];
            end
        end
    end

    // set while any motion is pending
    assign motion_flag = (acc[0] != '0) || (acc[1] != '0);

    ////////////////////////////////////////////////////////////////////////////
    // overflow: a new overflow wins over any clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag <= 1'b0;
        end else if (|sat_axis) begin
            overflow_flag <= 1'b1;
        end else if (wr_event) begin
            overflow_flag <= 1'b0;
        end else if ((|rd_axis) && !(|full_axis)) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_seen_flag <= 1'b1;
        end else if (soft_reset) begin
            reset_seen_flag <= 1'b1;
        end else if (wr_event) begin
            reset_seen_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            finger_prev <= 1'b0;
        end else begin
            finger_prev <= finger_present;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags: 4 pixel first, 3 pixel ready, 2 button, 1 tap, 0 finger
    // port write or wrap
    assign sticky_set[4] = hit(wr, link.addr, mer_pkg::ADDR_PIXEL) || pixel_wrap;
    assign sticky_set[3] = pixel_valid;
    assign sticky_set[2] = button_click;
    assign sticky_set[1] = tap_click;
    assign sticky_set[0] = finger_prev != finger_present;
    assign sticky_clr[4] = rd_pixel;
    assign sticky_clr[3] = rd_pixel;
    assign sticky_clr[2] = hit(rd, link.addr, mer_pkg::ADDR_BUTTON);
    assign sticky_clr[1] = hit(rd, link.addr, mer_pkg::ADDR_TAP);
    assign sticky_clr[0] = hit(rd, link.addr, mer_pkg::ADDR_FINGER);

    for (genvar s = 0; s < 5; s++) begin : g_sticky
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sticky[s] <= 1'b0;
            end else if (sticky_set[s]) begin
                sticky[s] <= 1'b1;
            end else if (sticky_clr[s]) begin
                sticky[s] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // low byte frozen at the high byte read, so the pair is coherent
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exp_low_hold <= '0;
        end else if (hit(rd, link.addr, mer_pkg::ADDR_EXP_HI)) begin
            exp_low_hold <= exposure[7:0];
        end
    end

    assign surface_quality = (feature_count[8:1] > mer_pkg::SURFACE_QUALITY_MAX) ? mer_pkg::SURFACE_QUALITY_MAX : feature_count[8:1];

    always_comb begin
        event_byte = '0;
        event_byte[mer_pkg::EV_MOTION] = motion_flag;
        event_byte[mer_pkg::EV_PIX_RDY] = sticky[3];
        event_byte[mer_pkg::EV_PIX_FIRST] = sticky[4];
        event_byte[mer_pkg::EV_OVF] = overflow_flag;
        event_byte[mer_pkg::EV_RESET] = reset_seen_flag;
        event_byte[mer_pkg::EV_BUTTON] = sticky[2];
        event_byte[mer_pkg::EV_TAP] = sticky[1];
        event_byte[mer_pkg::EV_FINGER] = sticky[0];
    end

    always_comb begin
        next_rdata = '0;
        case (link.addr)
            mer_pkg::ADDR_EVENT: next_rdata = event_byte;
            mer_pkg::ADDR_DX: next_rdata = rep[0];
            mer_pkg::ADDR_DY: next_rdata = rep[1];
            mer_pkg::ADDR_SURFACE_QUALITY: next_rdata = surface_quality;
            mer_pkg::ADDR_EXP_HI: next_rdata = exposure[15:8];
            mer_pkg::ADDR_EXP_LO: next_rdata = exp_low_hold;
            mer_pkg::ADDR_PIXEL: next_rdata = pixel_byte;
            mer_pkg::ADDR_BUTTON: next_rdata = button_state;
            mer_pkg::ADDR_TAP: next_rdata = tap_state;
            mer_pkg::ADDR_FINGER: next_rdata = {7'h00, finger_present};
            default: next_rdata = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.ack <= 1'b0;
            link.rdata <= '0;
        end else begin
            link.ack <= take;
            if (rd) begin
                link.rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pixel_restart <= 1'b0;
            pixel_advance <= 1'b0;
        end else begin
            pixel_restart <= hit(wr, link.addr, mer_pkg::ADDR_PIXEL);
            pixel_advance <= rd_pixel;
        end
    end

endmodule

// ===== testbench/mer_link_monitor.sv
`timescale 1ns/1ps
module mer_link_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire take = req && !ack;
    ////////////////////////////////////////////////////////////
    ack_answer_a: assert property (take |=> ack) else $error("no ack");
    ack_pulse_a: assert property (ack |=> !ack) else $error("long ack");
    ack_cause_a: assert property (ack |-> $past(take)) else $error("stray ack");
    req_held_a: assert property (take |=> req && $stable(addr)) else $error("req moved");
    req_drop_a: assert property (ack |=> !req) else $error("req kept");
    surface_quality_cap_a: assert property (take && !we && addr == mer_pkg::ADDR_SURFACE_QUALITY
        |=> rdata <= mer_pkg::SURFACE_QUALITY_MAX) else $error("quality too big");
    write_unstored_a: assert property (take && we |=> $stable(rdata)) else $error("write stored");
    finger_byte_a: assert property (take && !we && addr == mer_pkg::ADDR_FINGER
        |=> rdata[7:1] == 7'h00) else $error("finger byte");
    cover property (take && we && addr == mer_pkg::ADDR_EVENT);
    cover property (take && !we && addr == mer_pkg::ADDR_DX);
    cover property (take && !we && addr == mer_pkg::ADDR_EXP_LO);
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic motion_valid = 1'b0, button_click = 1'b0, tap_click = 1'b0;
    logic finger_present = 1'b0, pixel_valid = 1'b0, pixel_wrap = 1'b0, soft_reset = 1'b0;
    logic signed [7:0] motion_dx = 8'sh00, motion_dy = 8'sh00;
    logic [8:0] feature_count = 9'h1FF;
    logic [15:0] exposure = 16'h1234;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, d;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rs;
    int fail_count = 0;
    int checks = 0;
    mer_link_if link ();
    always #12.5 aclk = ~aclk;
    mer_device u_mer_device (.link(link), .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
        .motion_valid(motion_valid), .motion_dx(motion_dx), .motion_dy(motion_dy),
        .feature_count(feature_count), .exposure(exposure), .button_click(button_click),
        .tap_click(tap_click), .finger_present(finger_present), .button_state(8'h5A),
        .tap_state(8'hC3), .pixel_valid(pixel_valid), .pixel_byte(8'h6E), .pixel_wrap(pixel_wrap),
        .pixel_restart(), .pixel_advance());
    mer_host u_mer_host (.link(link), .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    mer_link_monitor u_mer_link_monitor (.aclk(aclk), .aresetn(aresetn), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
    ////////////////////////////////////////////////////////////
    task ck(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            $display("[FAIL] %s exp %h got %h", n, e, s);
            fail_count++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is released on its own handshake
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        v = rdata;
        rs = rresp;
    endtask
    // busy poll bounded; a hang ends at the watchdog
    task lk(input logic [7:0] a, input logic [1:0] w, output logic [7:0] q);
        wr(8'h00, {8'h00, 8'hA5, a, 6'h00, w});
        st = 32'h1;
        for (int i = 0; i < 50 && st[0] !== 1'b0; i++) rd(8'h04, st);
        q = st[15:8];
    endtask
    task lc(input logic [7:0] a, input logic [7:0] e);
        lk(a, 2'h0, d);
        ck($sformatf("link %h", a), e, d);
    endtask
    task end_of_test;
        $display("checks %0d fails %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        fail_count++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        lc(8'h02, 8'h08);
        lk(8'h02, 2'h1, d);
        lc(8'h02, 8'h00);
        $display("reset flag test done");
        motion_valid <= 1'b1;
        motion_dx <= 8'sh05;
        motion_dy <= -8'sh03;
        @(posedge aclk);
        motion_valid <= 1'b0;
        lc(8'h02, 8'h80);
        lc(8'h03, 8'h05);
        lc(8'h04, 8'hFD);
        lc(8'h02, 8'h00);
        motion_valid <= 1'b1;
        motion_dx <= 8'sh7F;
        repeat (17) @(posedge aclk);
        motion_valid <= 1'b0;
        lc(8'h02, 8'h90);
        lc(8'h03, 8'h7F);
        lc(8'h02, 8'h80);
        lk(8'h02, 2'h1, d);
        lc(8'h04, 8'h00);
        lc(8'h02, 8'h00);
        $display("motion test done");
        button_click <= 1'b1;
        tap_click <= 1'b1;
        pixel_valid <= 1'b1;
        pixel_wrap <= 1'b1;
        finger_present <= 1'b1;
        soft_reset <= 1'b1;
        @(posedge aclk);
        button_click <= 1'b0;
        tap_click <= 1'b0;
        pixel_valid <= 1'b0;
        pixel_wrap <= 1'b0;
        soft_reset <= 1'b0;
        lc(8'h02, 8'h6F);
        lc(8'h12, 8'h5A);
        lc(8'h7F, 8'hC3);
        lc(8'h7A, 8'h01);
        lc(8'h0B, 8'h6E);
        lc(8'h02, 8'h08);
        lk(8'h0B, 2'h1, d);
        lc(8'h02, 8'h28);
        $display("event test done");
        lc(8'h05, 8'hA7);
        feature_count <= 9'h0A5;
        lc(8'h05, 8'h52);
        lc(8'h06, 8'h12);
        exposure <= 16'hABCD;
        lc(8'h07, 8'h34);
        motion_valid <= 1'b1;
        repeat (2) @(posedge aclk);
        motion_valid <= 1'b0;
        lk(8'h00, 2'h2, d);
        rd(8'h08, st);
        ck("poll sums", 32'hFFFA00FE, st);
        lk(8'h00, 2'h3, d);
        rd(8'h0C, st);
        ck("expo op", 32'h0000ABCD, st);
        $display("quality exposure test done");
        rd(8'h10, st);
        ck("irq status", 32'h3, st);
        ck("irq masked", 1'b0, irq);
        wr(8'h14, 32'h1);
        repeat (2) @(posedge aclk);
        ck("irq raised", 1'b1, irq);
        wr(8'h10, 32'h1);
        repeat (2) @(posedge aclk);
        ck("irq cleared", 1'b0, irq);
        rd(8'h18, st);
        ck("unmapped resp", 2'h2, rs);
        $display("irq test done");
        end_of_test;
    end
endmodule
